// File: src/disconnector_supervisor.sv
// Disconnector supervisor: periodic state check, malfunction handling,
// disconnection reason and event logging behind an AHB-Lite slave.
// Assumes one AHB master, zero-wait answers, and an asynchronous
// load-side voltage sense input.
//
// Overview of operation
// - Compare sensed physical state with control state every 10 seconds.
// - Third mismatch sets malfunction and warning and logs a malfunction.
// - A successful operation clears malfunction but keeps the warning.
// - Each mismatching check repeats the disconnector operation.
// - Agreement after malfunction logs restoration, clears malfunction.
// - Opening before malfunction moves control state to disconnected.
// - Hold reason code: 0,1,2,3,6,7 as power loss through unknown.
// - Codes 1 and 2 are high priority, 3 and 6 lower.
// - Equal priority reasons are shown in order of occurrence.
// - A high reason after a lower one is shown first.
// - Leaving high reason into ready-for-connection shows code 7.
// - Event records hold code and time, up to 200 of them.
// - Malfunction logs code 20, restoration logs code 21.
// - Control state is one of four codes 0 to 3.
// - Load-side voltage present means physically connected.
//
// Local design decisions: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module disconnector_supervisor
    import disc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_SECOND_CYCLES
)
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Disconnector side
    input wire logic load_voltage,
    output logic relay_connect,
    output logic relay_retry,
    // Indications
    output logic malfunction,
    output logic warning,
    output logic irq
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [31:0] hrdata_reg, rd_data, tick_cnt_reg, seconds_reg;
    logic [7:0] wr_addr_reg, log_idx_reg, log_count, log_ptr;
    logic wr_pend_reg, ready_reg, sec_tick_reg, check_now;
    logic [3:0] chk_cnt_reg;
    logic phys_s1_reg, phys_s2_reg, phys_s3_reg, phys_reg, phys_fall;
    logic [1:0] ctrl_reg, mis_cnt_reg, int_stat_reg, int_en_reg;
    logic [2:0] reason_reg;
    logic retry_reg, warn_reg, irq_reg, mismatch, log_wr_reg, relay_conn_reg;
    logic [7:0] log_code_reg;
    logic [7:0] hsize_unused;
    sup_state_t state_reg;
    log_rec_t log_rd;
    log_rec_t log_wr_rec;

    // High priority reasons
    function automatic logic is_high(input logic [2:0] code);
        return code == RSN_COMMAND || code == RSN_SCHEDULE;
    endfunction

    // Lower priority reasons
    function automatic logic is_low(input logic [2:0] code);
        return code == RSN_OVERLOAD || code == RSN_MANUAL;
    endfunction

    // Data-phase write strobe for one register
    function automatic logic wr_hit(input logic [7:0] off);
        return wr_pend_reg && wr_addr_reg == off;
    endfunction

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    // Address phase capture and registered read data, zero wait
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata_reg <= 32'h0000_0000;
            ready_reg <= 1'b0;
        end
        else
        begin
            ready_reg <= 1'b1;
            wr_pend_reg <= hsel && hready && htrans[1] && hwrite;
            wr_addr_reg <= haddr[7:0];
            if (hsel && hready && htrans[1] && !hwrite)
            begin
                hrdata_reg <= rd_data;
            end
        end
    end

    // Read multiplexer, unmapped offsets read zero
    always_comb
    begin
        rd_data = 32'h0000_0000;
        unique case (haddr[7:0])
            OFF_CTRL: rd_data[1:0] = ctrl_reg;
            OFF_STATUS:
            begin
                rd_data[ST_MALF_BIT] = malfunction;
                rd_data[ST_WARN_BIT] = warn_reg;
                rd_data[ST_PHYS_BIT] = phys_reg;
                rd_data[ST_CNT_LSB +: 2] = mis_cnt_reg;
            end
            OFF_REASON: rd_data[2:0] = reason_reg;
            OFF_LOG_IDX: rd_data[7:0] = log_idx_reg;
            OFF_LOG_CODE: rd_data[7:0] = log_rd.code;
            OFF_LOG_TIME: rd_data = log_rd.stamp;
            OFF_LOG_INFO: rd_data[15:0] = {log_ptr, log_count};
            OFF_INT_STAT: rd_data[1:0] = int_stat_reg;
            OFF_INT_EN: rd_data[1:0] = int_en_reg;
            OFF_SECONDS: rd_data = seconds_reg;
            default: rd_data = 32'h0000_0000;
        endcase
    end

    assign hsize_unused = {5'h00, hsize};
    assign hrdata = hrdata_reg;
    assign hreadyout = ready_reg;
    assign hresp = 1'b0;

    // ------------------------------------------------------------
    // Time base
    // ------------------------------------------------------------
    // Seconds tick, time stamp and check interval counter
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tick_cnt_reg <= 32'h0000_0000;
            sec_tick_reg <= 1'b0;
            seconds_reg <= 32'h0000_0000;
            chk_cnt_reg <= 4'h0;
        end
        else
        begin
            sec_tick_reg <= tick_cnt_reg == 32'(TICK_CYCLES - 1);
            if (tick_cnt_reg == 32'(TICK_CYCLES - 1))
                tick_cnt_reg <= 32'h0000_0000;
            else
                tick_cnt_reg <= tick_cnt_reg + 32'h1;
            if (sec_tick_reg)
            begin
                seconds_reg <= seconds_reg + 32'h1;
                chk_cnt_reg <= check_now ? 4'h0 : chk_cnt_reg + 4'h1;
            end
        end
    end

    assign check_now = sec_tick_reg && chk_cnt_reg == CHECK_LAST;

    // ------------------------------------------------------------
    // Physical state sensing
    // ------------------------------------------------------------
    // Three-stage synchroniser, change taken when stages two and three agree
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            phys_s1_reg <= 1'b0;
            phys_s2_reg <= 1'b0;
            phys_s3_reg <= 1'b0;
            phys_reg <= 1'b0;
        end
        else
        begin
            phys_s1_reg <= load_voltage;
            phys_s2_reg <= phys_s1_reg;
            phys_s3_reg <= phys_s2_reg;
            if (phys_s2_reg == phys_s3_reg)
                phys_reg <= phys_s3_reg;
        end
    end

    assign phys_fall = phys_reg && !phys_s2_reg && !phys_s3_reg;
    assign mismatch = phys_reg != (ctrl_reg == CTRL_CONN);

    // ------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------
    // Software sets the state; an early opening forces disconnected
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ctrl_reg <= CTRL_DISC;
        else if (phys_fall && ctrl_reg == CTRL_CONN && state_reg == SUP_NORMAL)
            ctrl_reg <= CTRL_DISC;
        else if (wr_hit(OFF_CTRL))
            ctrl_reg <= hwdata[1:0];
    end

    // ------------------------------------------------------------
    // Malfunction supervision
    // ------------------------------------------------------------
    // Mismatch counting, retries, malfunction and log requests
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_reg <= SUP_NORMAL;
            mis_cnt_reg <= 2'h0;
            retry_reg <= 1'b0;
            log_wr_reg <= 1'b0;
            log_code_reg <= 8'h00;
        end
        else
        begin
            retry_reg <= check_now && mismatch;
            log_wr_reg <= 1'b0;
            if (check_now && mismatch && state_reg == SUP_NORMAL)
            begin
                mis_cnt_reg <= mis_cnt_reg + 2'h1;
                if (mis_cnt_reg == MISMATCH_LIMIT - 2'h1)
                begin
                    state_reg <= SUP_FAULT;
                    log_wr_reg <= 1'b1;
                    log_code_reg <= EV_MALFUNCTION;
                end
            end
            else if (check_now && !mismatch)
            begin
                mis_cnt_reg <= 2'h0;
                if (state_reg == SUP_FAULT)
                begin
                    state_reg <= SUP_NORMAL;
                    log_wr_reg <= 1'b1;
                    log_code_reg <= EV_RESTORATION;
                end
            end
        end
    end

    // Warning: set on malfunction, cleared only by software, set wins
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            warn_reg <= 1'b0;
        else if (log_wr_reg && log_code_reg == EV_MALFUNCTION)
            warn_reg <= 1'b1;
        else if (wr_hit(OFF_STATUS) && hwdata[ST_WARN_BIT])
            warn_reg <= 1'b0;
    end

    // ------------------------------------------------------------
    // Disconnection reason
    // ------------------------------------------------------------
    // Priority update of the reason code
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            reason_reg <= RSN_POWER_LOSS;
        else if (wr_hit(OFF_CTRL) && hwdata[1:0] == CTRL_READY
                 && ctrl_reg == CTRL_DISC && is_high(reason_reg))
            reason_reg <= RSN_UNKNOWN;
        else if (wr_hit(OFF_REASON))
        begin
            if (is_high(hwdata[2:0]))
                reason_reg <= hwdata[2:0];
            else if (is_low(hwdata[2:0]) && !is_high(reason_reg))
                reason_reg <= hwdata[2:0];
            else if (hwdata[2:0] == RSN_POWER_LOSS
                     || hwdata[2:0] == RSN_UNKNOWN)
                reason_reg <= hwdata[2:0];
        end
    end

    // ------------------------------------------------------------
    // Event log and interrupts
    // ------------------------------------------------------------
    // Record handed to the log: event code and seconds since reset
    assign log_wr_rec = '{code: log_code_reg, stamp: seconds_reg};

    event_log u_log (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr_en(log_wr_reg),
        .wr_rec(log_wr_rec),
        .rd_idx(log_idx_reg),
        .rd_rec(log_rd),
        .count(log_count),
        .wr_ptr(log_ptr)
    );

    // Log index, interrupt status, enable and output
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            log_idx_reg <= 8'h00;
            int_stat_reg <= 2'h0;
            int_en_reg <= 2'h0;
            irq_reg <= 1'b0;
        end
        else
        begin
            if (wr_hit(OFF_LOG_IDX))
                log_idx_reg <= hwdata[7:0];
            if (wr_hit(OFF_INT_EN))
                int_en_reg <= hwdata[1:0];
            int_stat_reg <= (int_stat_reg
                & ~(wr_hit(OFF_INT_CLR) ? hwdata[1:0] : 2'h0))
                | {log_wr_reg && log_code_reg == EV_RESTORATION,
                   log_wr_reg && log_code_reg == EV_MALFUNCTION};
            irq_reg <= |(int_stat_reg & int_en_reg);
        end
    end

    // Relay coil command, registered so the pin comes from a flip-flop
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            relay_conn_reg <= 1'b0;
        else
            relay_conn_reg <= ctrl_reg == CTRL_CONN;
    end

    assign relay_connect = relay_conn_reg;
    assign relay_retry = retry_reg;
    assign malfunction = state_reg[1]; // One-hot fault bit
    assign warning = warn_reg;
    assign irq = irq_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    retry_on_mismatch_a: assert property (
        check_now && mismatch |=> relay_retry ##1 !relay_retry)
        else $error("no single retry pulse after a mismatching check");
    third_mismatch_a: assert property (
        check_now && mismatch && !malfunction && mis_cnt_reg == 2'h2
        |=> malfunction && log_wr_reg && log_code_reg == 8'd20
        ##1 warning)
        else $error("third mismatch did not declare a malfunction");
    early_mismatch_a: assert property (
        check_now && mismatch && !malfunction && mis_cnt_reg < 2'h2
        |=> !malfunction && !log_wr_reg)
        else $error("malfunction declared before the third mismatch");
    count_clear_a: assert property (
        check_now && !mismatch |=> mis_cnt_reg == 2'h0 && !relay_retry)
        else $error("agreeing check left the mismatch count set");
    restore_log_a: assert property (
        check_now && !mismatch && malfunction
        |=> !malfunction && log_wr_reg && log_code_reg == 8'd21)
        else $error("restoration not logged");
    warn_kept_a: assert property (
        $fell(malfunction) |-> warning)
        else $error("warning lost when malfunction cleared");
    early_open_a: assert property (
        phys_fall && ctrl_reg == CTRL_CONN && !malfunction
        |=> ctrl_reg == CTRL_DISC)
        else $error("early opening did not force disconnected");
    reason_prio_a: assert property (
        is_high(reason_reg) && wr_hit(OFF_REASON)
        && is_low(hwdata[2:0]) && !wr_hit(OFF_CTRL) |=> $stable(reason_reg))
        else $error("lower reason displaced a high reason");
    check_gap_a: assert property (
        check_now |=> !check_now [*8])
        else $error("checks closer than the interval");

    mal_c: cover property (check_now && mismatch ##1 malfunction);
    rest_c: cover property ($fell(malfunction));
    open_c: cover property (phys_fall && ctrl_reg == CTRL_CONN);
    unknown_c: cover property (reason_reg == RSN_UNKNOWN);

endmodule // disconnector_supervisor
`default_nettype wire

// File: src/disc_pkg.sv
// Package for the disconnector supervisor: register map, field codes,
// timing counts, record layout and supervisor states.
// Assumes a 20 MHz bus clock and 32-bit AHB-Lite data.
`default_nettype none
package disc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned CHECK_PERIOD_S = 10;
    localparam int unsigned TICK_SECOND_CYCLES = CLK_HZ * 1;
    localparam logic [3:0] CHECK_LAST = 4'(CHECK_PERIOD_S - 1);
    localparam logic [1:0] MISMATCH_LIMIT = 2'h3;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_REASON = 8'h08;
    localparam logic [7:0] OFF_LOG_IDX = 8'h0c;
    localparam logic [7:0] OFF_LOG_CODE = 8'h10;
    localparam logic [7:0] OFF_LOG_TIME = 8'h14;
    localparam logic [7:0] OFF_LOG_INFO = 8'h18;
    localparam logic [7:0] OFF_INT_STAT = 8'h1c;
    localparam logic [7:0] OFF_INT_CLR = 8'h20;
    localparam logic [7:0] OFF_INT_EN = 8'h24;
    localparam logic [7:0] OFF_SECONDS = 8'h28;

    // Status fields
    localparam int unsigned ST_MALF_BIT = 0;
    localparam int unsigned ST_WARN_BIT = 1;
    localparam int unsigned ST_PHYS_BIT = 2;
    localparam int unsigned ST_CNT_LSB = 4;
    localparam int unsigned INT_MALF_BIT = 0;
    localparam int unsigned INT_REST_BIT = 1;

    // ------------------------------------------------------------
    // Control states and reasons
    // ------------------------------------------------------------
    localparam logic [1:0] CTRL_DISC = 2'h0;
    localparam logic [1:0] CTRL_CONN = 2'h1;
    localparam logic [1:0] CTRL_READY_LOCK = 2'h2;
    localparam logic [1:0] CTRL_READY = 2'h3;

    localparam logic [2:0] RSN_POWER_LOSS = 3'h0;
    localparam logic [2:0] RSN_COMMAND = 3'h1;
    localparam logic [2:0] RSN_SCHEDULE = 3'h2;
    localparam logic [2:0] RSN_OVERLOAD = 3'h3;
    localparam logic [2:0] RSN_MANUAL = 3'h6;
    localparam logic [2:0] RSN_UNKNOWN = 3'h7;

    // ------------------------------------------------------------
    // Event log
    // ------------------------------------------------------------
    localparam int unsigned LOG_DEPTH = 200;
    localparam logic [7:0] LOG_LAST = 8'(LOG_DEPTH - 1);
    localparam logic [7:0] LOG_FULL = 8'(LOG_DEPTH);
    localparam logic [7:0] EV_MALFUNCTION = 8'd20;
    localparam logic [7:0] EV_RESTORATION = 8'd21;

    typedef struct packed {
        logic [7:0] code;
        logic [31:0] stamp;
    } log_rec_t;

    typedef enum logic [1:0] {
        SUP_NORMAL = 2'b01,
        SUP_FAULT = 2'b10
    } sup_state_t;

endpackage
`default_nettype wire

// File: src/event_log.sv
// Circular store of event records, code plus time stamp.
// Assumes one write pulse per record from the supervisor's clock domain.
`timescale 1ns/1ps
`default_nettype none
module event_log
    import disc_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Write side
    input wire logic wr_en,
    input wire log_rec_t wr_rec,
    // Read side
    input wire logic [7:0] rd_idx,
    output log_rec_t rd_rec,
    output logic [7:0] count,
    output logic [7:0] wr_ptr
);

    log_rec_t mem_reg [LOG_DEPTH];
    logic [7:0] count_reg;
    logic [7:0] ptr_reg;

    // Record storage, the oldest slot is overwritten once full
    always_ff @(posedge hclk)
    begin
        if (wr_en)
        begin
            mem_reg[ptr_reg] <= wr_rec;
        end
    end

    // Write pointer and fill level
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ptr_reg <= 8'h00;
            count_reg <= 8'h00;
        end
        else if (wr_en)
        begin
            ptr_reg <= (ptr_reg == LOG_LAST) ? 8'h00 : ptr_reg + 8'h01;
            if (count_reg != LOG_FULL)
            begin
                count_reg <= count_reg + 8'h01;
            end
        end
    end

    // Slots beyond the depth read as zero
    assign rd_rec = (rd_idx <= LOG_LAST) ? mem_reg[rd_idx] : '0;
    assign count = count_reg;
    assign wr_ptr = ptr_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    log_cap_a: assert property (@(posedge hclk) disable iff (!hresetn)
        count_reg <= LOG_FULL && ptr_reg <= LOG_LAST)
        else $error("event log level or pointer out of range");

endmodule // event_log
`default_nettype wire

// File: dv/relay_model.sv
// Behavioural relay driver with load-side voltage sensing.
// Assumes the supervisor's clock; stuck_open comes from the bench.
`timescale 1ns/1ps
`default_nettype none
module relay_model
(
    // Clock
    input wire logic hclk,
    // Relay side
    input wire logic relay_connect,
    input wire logic stuck_open,
    output logic load_voltage
);
    logic [2:0] dly_reg = 3'h0;

    // Contacts settle three cycles after the coil command, no inrush modelled
    always_ff @(posedge hclk)
        dly_reg <= {dly_reg[1:0], relay_connect & ~stuck_open};
    assign load_voltage = dly_reg[2];
endmodule // relay_model
`default_nettype wire

// File: dv/disconnector_supervisor_tb_top.sv
// Bench for the disconnector supervisor.
// Assumes the supervisor and relay_model; one AHB-Lite master.
`timescale 1ns/1ps
`default_nettype none
module disconnector_supervisor_tb_top;
    import disc_pkg::*;
    logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    logic hreadyout, hresp, load_voltage, relay_connect, relay_retry;
    logic malfunction, warning, irq, stuck_open = 1'b0;
    int errors = 0, cmp_count = 0, cyc = 0, last = 0, retries = 0;

    disconnector_supervisor #(.TICK_CYCLES(4)) disconnector_supervisor_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .load_voltage(load_voltage), .relay_connect(relay_connect),
        .relay_retry(relay_retry), .malfunction(malfunction),
        .warning(warning), .irq(irq));
    relay_model relay_model_i (.hclk(hclk),
        .relay_connect(relay_connect), .stuck_open(stuck_open),
        .load_voltage(load_voltage));

    // Clock, 50 ns period
    initial
    begin
        forever #25 hclk = ~hclk;
    end

    // ----------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------
    task test_done;
        if (errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            errors++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask

    // One single AHB transfer, bounded waits on hready
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        n = 0;
        do begin @(posedge hclk); n++; end
        while (hreadyout !== 1'b1 && n < 50);
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge hclk); n++; end
        while (hreadyout !== 1'b1 && n < 100);
        r = hrdata;
        if (n >= 100)
        begin
            errors++;
            test_done;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a,
                          input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk(nm, e, r);
    endtask

    task automatic wait_malf(input logic v);
        int n;
        n = 0;
        while (malfunction !== v && n < 400)
        begin
            @(posedge hclk);
            n++;
        end
        if (n >= 400)
        begin
            errors++;
            test_done;
        end
    endtask

    // Retry pulses come exactly one check period apart
    always @(posedge hclk)
    begin
        cyc++;
        if (relay_retry === 1'b1)
        begin
            retries++;
            if (last != 0) chk("retry_gap", 32'd40, cyc - last);
            last = cyc;
        end
    end

    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    task automatic t_reset;
        rd_chk("status", OFF_STATUS, 32'h0);
        rd_chk("reason", OFF_REASON, 32'h0);
        chk("hresp", 32'h0, hresp);
    endtask

    task automatic t_malfunction;
        stuck_open <= 1'b1;
        wr(OFF_INT_EN, 32'h3);
        wr(OFF_CTRL, 32'h1);
        wait_malf(1'b1);
        repeat (4) @(posedge hclk);
        chk("retries", 32'd3, retries);
        chk("warning", 32'h1, warning);
        chk("relay_connect", 32'h1, relay_connect);
        chk("irq", 32'h1, irq);
        rd_chk("int_stat", OFF_INT_STAT, 32'h1);
        rd_chk("log_info", OFF_LOG_INFO, 32'h0101);
        wr(OFF_LOG_IDX, 32'h0);
        rd_chk("log_code", OFF_LOG_CODE, 32'd20);
        wr(OFF_INT_CLR, 32'h1);
        repeat (3) @(posedge hclk);
        chk("irq_clr", 32'h0, irq);
        repeat (45) @(posedge hclk);
        chk("retry_more", 32'd4, retries);
    endtask

    task automatic t_restore;
        wr(OFF_INT_EN, 32'h0);
        stuck_open <= 1'b0;
        wait_malf(1'b0);
        repeat (4) @(posedge hclk);
        chk("warn_kept", 32'h1, warning);
        chk("irq_masked", 32'h0, irq);
        rd_chk("int_stat2", OFF_INT_STAT, 32'h2);
        wr(OFF_LOG_IDX, 32'h1);
        rd_chk("log_code2", OFF_LOG_CODE, 32'd21);
        wr(OFF_STATUS, 32'h2);
        rd_chk("status_w1c", OFF_STATUS, 32'h4);
    endtask

    task automatic t_early_open;
        stuck_open <= 1'b1;
        repeat (10) @(posedge hclk);
        rd_chk("ctrl_open", OFF_CTRL, 32'h0);
        chk("relay_open", 32'h0, relay_connect);
        repeat (100) @(posedge hclk);
        chk("no_malf", 32'h0, malfunction);
    endtask

    task automatic t_reasons;
        logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
        foreach (codes[i])
        begin
            wr(OFF_REASON, 32'h0);
            wr(OFF_REASON, {29'h0, codes[i]});
            rd_chk("reason_code", OFF_REASON, {29'h0, codes[i]});
        end
        wr(OFF_REASON, 32'h3);
        wr(OFF_REASON, 32'h1);
        rd_chk("high_first", OFF_REASON, 32'h1);
        wr(OFF_REASON, 32'h6);
        rd_chk("low_held", OFF_REASON, 32'h1);
        wr(OFF_REASON, 32'h2);
        rd_chk("time_order", OFF_REASON, 32'h2);
        wr(OFF_CTRL, 32'h3);
        rd_chk("unknown", OFF_REASON, 32'h7);
    endtask

    // Main sequence
    initial
    begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        t_reset();
        t_malfunction();
        t_restore();
        t_early_open();
        t_reasons();
        test_done();
    end
endmodule // disconnector_supervisor_tb_top
`default_nettype wire
